// >>> src/display_controller.sv
`timescale 1ns/1ps
// Contract
// - At power-up display memory is filled from the straps: 1/1 off, 1/0 on, 0/1 pattern one, 0/0 pattern two.
// - An open test strap reads as one and an open lamp strap as zero, so every segment lights.
// - Either test pattern also sounds the beeper without any host command.
// - The controller clock is a square wave at half the host bus clock.
// - The active-high controller reset falls after the reset interval and its active-low twin is then high.
// - Hold-off is high during reset and falls only after reset has fallen; while high the host is held off.
// - Eleven grids numbered 10 down to 0 left to right; a driven grid enables its digit, an idle one disables it.
// - A segment lights only while its anode and its digit's grid are both driven.
// - A watchdog reset exists and is disabled while its test input is held low.
`include "display_consts.svh"

module display_controller
    import display_pkg::*;
#(
    parameter int GRID_COUNT      = `GRID_COUNT,
    parameter int SEG_W           = `SEG_WIDTH,
    parameter int RESET_CYCLES    = `RESET_CYCLES,
    parameter int DIGIT_CYCLES    = `DIGIT_CYCLES,
    parameter int BEEP_CYCLES     = `BEEP_CYCLES,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             host_bus_clock,
    input  wire logic             pattern_select_strap_n,
    input  wire logic             lamp_pattern_strap_n,
    input  wire logic             pattern_strap_present,
    input  wire logic             lamp_strap_present,
    input  wire logic             watchdog_test_n,
    input  wire logic             host_command_data,
    input  wire logic             host_command_clock,
    output logic                  controller_clock,
    output logic                  controller_reset,
    output logic                  controller_reset_n,
    output logic                  controller_hold_off,
    output logic [GRID_COUNT-1:0] grid,
    output logic [SEG_W-1:0]      anode,
    output logic                  beeper
);
    localparam int CNT_W = 26;
    localparam int ADDR_W = `ADDR_WIDTH;
    localparam int CMD_W = ADDR_W + SEG_W;
    localparam logic [31:0] PAT1 = `PATTERN_ONE_WORD;
    localparam logic [31:0] PAT2 = `PATTERN_TWO_WORD;

    ////////////////////////////////////////////////////////////////////////
    ctl_state_e             state_ff, nxt_state;
    init_pattern_e          pat_ff;
    logic [CNT_W-1:0]       rst_cnt_ff, beep_cnt_ff, wdog_cnt_ff, scan_cnt_ff;
    logic [ADDR_W-1:0]      fill_idx_ff, digit_ff;
    logic [SEG_W-1:0]       mem_ff [GRID_COUNT];
    logic                   creset_ff, creset_n_ff, hold_off_ff;
    logic                   cclk_ff, prev_bus_ff, prev_sclk_ff, beeper_ff;
    logic [CMD_W-1:0]       shift_ff;
    logic [4:0]             bit_cnt_ff;
    logic [CMD_W-1:0]       buf_ff [2];
    logic                   wr_ptr_ff, rd_ptr_ff;
    logic [1:0]             buf_cnt_ff;
    logic [GRID_COUNT-1:0]  grid_ff, nxt_grid;
    logic [SEG_W-1:0]       anode_ff;

    function automatic init_pattern_e decode_straps(logic test_n,
                                                    logic lamp_n);
        case ({test_n, lamp_n})
            2'b11:   return pat_off;
            2'b10:   return pat_on;
            2'b01:   return pat_one;
            default: return pat_two;
        endcase
    endfunction

    function automatic logic [SEG_W-1:0] fill_word(init_pattern_e p,
                                                   logic [ADDR_W-1:0] d);
        case (p)
            pat_off: return '0;
            pat_on:  return '1;
            pat_one: return d[0] ? ~PAT1[SEG_W-1:0] : PAT1[SEG_W-1:0];
            default: return d[0] ? ~PAT2[SEG_W-1:0] : PAT2[SEG_W-1:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Strap decode and sequencing
    wire logic eff_test_n = pattern_strap_present ? pattern_select_strap_n
                                                  : `STRAP_OPEN_PATTERN_N;
    wire logic eff_lamp_n = lamp_strap_present ? lamp_pattern_strap_n
                                               : `STRAP_OPEN_LAMP_N;
    wire init_pattern_e strap_pat = decode_straps(eff_test_n, eff_lamp_n);
    wire logic rst_done = rst_cnt_ff == CNT_W'(RESET_CYCLES - 1);
    wire logic fill_start = state_ff == st_hold && rst_done;
    wire logic fill_last = fill_idx_ff == ADDR_W'(GRID_COUNT - 1);
    wire logic wdog_on = watchdog_test_n;
    wire logic wdog_fire = wdog_on
                           && wdog_cnt_ff == CNT_W'(WATCHDOG_CYCLES - 1);
    wire logic test_pat = strap_pat == pat_one || strap_pat == pat_two;

    always_comb begin
        case (state_ff)
            st_hold: nxt_state = rst_done ? st_fill : st_hold;
            st_fill: nxt_state = fill_last ? st_run : st_fill;
            st_run:  nxt_state = wdog_fire ? st_hold : st_run;
            default: nxt_state = st_hold;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= st_hold;
            rst_cnt_ff <= '0;
            fill_idx_ff <= '0;
            pat_ff <= pat_on;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            rst_cnt_ff <= (state_ff == st_hold && !rst_done)
                          ? rst_cnt_ff + 1'b1 : '0;
            fill_idx_ff <= (state_ff == st_fill) ? fill_idx_ff + 1'b1 : '0;
            if (fill_start)
                pat_ff <= strap_pat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset outputs, hold-off and bus clock divider
    always_ff @(posedge clk) begin
        if (reset) begin
            creset_ff <= 1'b1;
            creset_n_ff <= 1'b0;
            hold_off_ff <= 1'b1;
            cclk_ff <= 1'b0;
            prev_bus_ff <= 1'b0;
        end else if (clk_en) begin
            creset_ff <= state_ff == st_hold;
            creset_n_ff <= state_ff != st_hold;
            hold_off_ff <= state_ff == st_hold || creset_ff
                           || buf_cnt_ff == 2'd2;
            prev_bus_ff <= host_bus_clock;
            if (host_bus_clock && !prev_bus_ff)
                cclk_ff <= ~cclk_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Beeper for test patterns
    always_ff @(posedge clk) begin
        if (reset) begin
            beep_cnt_ff <= '0;
            beeper_ff <= 1'b0;
        end else if (clk_en) begin
            if (fill_start && test_pat)
                beep_cnt_ff <= CNT_W'(BEEP_CYCLES);
            else if (beep_cnt_ff != '0)
                beep_cnt_ff <= beep_cnt_ff - 1'b1;
            beeper_ff <= beep_cnt_ff != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial command receiver
    wire logic sclk_rise = host_command_clock && !prev_sclk_ff;
    wire logic rx_bit = sclk_rise && !hold_off_ff;
    wire logic rx_done = rx_bit && bit_cnt_ff == 5'(CMD_W - 1);
    wire logic buf_in_ready = buf_cnt_ff != 2'd2;
    wire logic push = rx_done && buf_in_ready;
    wire logic pop = buf_cnt_ff != 2'd0 && state_ff == st_run;
    wire logic [CMD_W-1:0] head = buf_ff[rd_ptr_ff];
    wire logic [ADDR_W-1:0] cmd_addr = head[CMD_W-1 -: ADDR_W];
    wire logic cmd_ok = cmd_addr < ADDR_W'(GRID_COUNT);

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_sclk_ff <= 1'b0;
            shift_ff <= '0;
            bit_cnt_ff <= '0;
        end else if (clk_en) begin
            prev_sclk_ff <= host_command_clock;
            if (hold_off_ff)
                bit_cnt_ff <= '0;
            else if (rx_bit) begin
                shift_ff <= {shift_ff[CMD_W-2:0], host_command_data};
                bit_cnt_ff <= rx_done ? 5'd0 : bit_cnt_ff + 1'b1;
            end
        end
    end

    // Two-entry buffer; full raises hold-off to stall the host
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            buf_cnt_ff <= 2'd0;
        end else if (clk_en) begin
            if (push) begin
                buf_ff[wr_ptr_ff] <= {shift_ff[CMD_W-2:0], host_command_data};
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            if (push && !pop)
                buf_cnt_ff <= buf_cnt_ff + 2'd1;
            else if (pop && !push)
                buf_cnt_ff <= buf_cnt_ff - 2'd1;
        end
    end

    // Watchdog restarts on every received command
    always_ff @(posedge clk) begin
        if (reset)
            wdog_cnt_ff <= '0;
        else if (clk_en) begin
            if (!wdog_on || push || state_ff != st_run)
                wdog_cnt_ff <= '0;
            else
                wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display memory
    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (state_ff == st_fill)
                mem_ff[fill_idx_ff] <= fill_word(pat_ff, fill_idx_ff);
            else if (pop && cmd_ok)
                mem_ff[cmd_addr] <= head[SEG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Grid scan
    wire logic scanning = state_ff == st_run;
    wire logic slot_end = scan_cnt_ff == CNT_W'(DIGIT_CYCLES - 1);
    wire logic [ADDR_W-1:0] nxt_digit =
        (digit_ff == ADDR_W'(GRID_COUNT - 1)) ? '0 : digit_ff + 1'b1;

    for (genvar g = 0; g < GRID_COUNT; g++) begin : g_grid
        assign nxt_grid[g] = scanning && nxt_digit == ADDR_W'(g);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            scan_cnt_ff <= '0;
            digit_ff <= '0;
            grid_ff <= '0;
            anode_ff <= '0;
        end else if (clk_en) begin
            scan_cnt_ff <= (slot_end || !scanning) ? '0 : scan_cnt_ff + 1'b1;
            if (!scanning) begin
                grid_ff <= '0;
                anode_ff <= '0;
            end else if (slot_end) begin
                digit_ff <= nxt_digit;
                grid_ff <= nxt_grid;
                anode_ff <= mem_ff[nxt_digit];
            end
        end
    end

    assign controller_clock = cclk_ff;
    assign controller_reset = creset_ff;
    assign controller_reset_n = creset_n_ff;
    assign controller_hold_off = hold_off_ff;
    assign grid = grid_ff;
    assign anode = anode_ff;
    assign beeper = beeper_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !clk_en);

    property p_hold_in_reset;
        controller_reset |-> controller_hold_off;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset)
        else $error("hold-off low during reset");

    property p_hold_falls_late;
        $fell(controller_hold_off) |-> !controller_reset
                                       && !$past(controller_reset);
    endproperty
    a_hold_falls_late: assert property (p_hold_falls_late)
        else $error("hold-off fell before reset");

    property p_reset_pair;
        $fell(controller_reset) |-> controller_reset_n;
    endproperty
    a_reset_pair: assert property (p_reset_pair)
        else $error("reset twins disagree");

    property p_clock_half;
        host_bus_clock && !prev_bus_ff
            |=> controller_clock != $past(controller_clock);
    endproperty
    a_clock_half: assert property (p_clock_half)
        else $error("controller clock missed a bus edge");

    property p_beep;
        fill_start && test_pat |-> ##2 beeper;
    endproperty
    a_beep: assert property (p_beep)
        else $error("beeper silent on test pattern");

    property p_open_straps;
        fill_start && !pattern_strap_present && !lamp_strap_present
            |=> pat_ff == pat_on;
    endproperty
    a_open_straps: assert property (p_open_straps)
        else $error("open straps not all-on");

    property p_fill_value;
        state_ff == st_fill |=> mem_ff[$past(fill_idx_ff)]
            == fill_word(pat_ff, $past(fill_idx_ff));
    endproperty
    a_fill_value: assert property (p_fill_value)
        else $error("display memory fill wrong");

    property p_one_grid;
        $onehot0(grid) and (grid == '0 |-> anode == '0);
    endproperty
    a_one_grid: assert property (p_one_grid)
        else $error("grid scan not one-hot or anode lit without grid");

    property p_no_rx_held;
        controller_hold_off |=> bit_cnt_ff == '0;
    endproperty
    a_no_rx_held: assert property (p_no_rx_held)
        else $error("bits taken while held off");

    property p_wdog_off;
        !watchdog_test_n |=> wdog_cnt_ff == '0;
    endproperty
    a_wdog_off: assert property (p_wdog_off)
        else $error("watchdog runs while disabled");

    c_beep: cover property (fill_start && test_pat);
    c_command: cover property (pop && cmd_ok);
    c_watchdog: cover property (state_ff == st_run && wdog_fire);
    c_full: cover property (buf_cnt_ff == 2'd2);

endmodule // display_controller

// >>> include/display_consts.svh
`ifndef DISPLAY_CONSTS_SVH
`define DISPLAY_CONSTS_SVH

`define CLK_FREQ_HZ          50000000
`define GRID_COUNT           11
`define SEG_WIDTH            16
`define ADDR_WIDTH           4

// Timing figures in their own units
`define RESET_TIME_US        100
`define DIGIT_TIME_US        100
`define BEEP_TIME_MS         200
`define WATCHDOG_TIME_MS     500

// Derived cycle counts, least times rounded up (all exact here)
`define RESET_CYCLES    (`RESET_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define DIGIT_CYCLES    (`DIGIT_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define BEEP_CYCLES     (`BEEP_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define WATCHDOG_CYCLES (`WATCHDOG_TIME_MS * (`CLK_FREQ_HZ / 1000))

// Level read from a strap that is left open
`define STRAP_OPEN_PATTERN_N 1'b1
`define STRAP_OPEN_LAMP_N    1'b0

// Segment words of the two test patterns
`define PATTERN_ONE_WORD     32'haaaaaaaa
`define PATTERN_TWO_WORD     32'hf0f0f0f0

`endif

// >>> include/display_pkg.sv
package display_pkg;

    typedef enum logic [1:0] {
        st_hold,
        st_fill,
        st_run
    } ctl_state_e;

    typedef enum logic [1:0] {
        pat_off,
        pat_on,
        pat_one,
        pat_two
    } init_pattern_e;

endpackage

// >>> verification/host_link.sv
`timescale 1ns/1ps
module host_link (
    input  wire logic clk,
    input  wire logic hold_off,
    output logic      cmd_data,
    output logic      cmd_clock
);
    initial begin
        cmd_data  = 1'b0;
        cmd_clock = 1'b0;
    end

    // Serial clock rests low outside frames, each level held slow cycles
    task automatic send(input logic [19:0] word, input int slow);
        @(posedge clk);
        while (hold_off !== 1'b0) begin
            @(posedge clk);
        end
        for (int i = 19; i >= 0; i--) begin
            cmd_data  <= word[i];
            cmd_clock <= 1'b0;
            repeat (slow) @(posedge clk);
            cmd_clock <= 1'b1;
            repeat (slow) @(posedge clk);
        end
        cmd_clock <= 1'b0;
        cmd_data  <= ~word[0];
    endtask
endmodule // host_link

// >>> verification/fluorescent_display_controller_tb_top.sv
`timescale 1ns/1ps
module fluorescent_display_controller_tb_top
    import display_pkg::*;
;
    localparam int BEEP_N = 10;
    localparam int DIG_N  = 4;

    logic        clk, reset, clk_en, host_bus_clock, watchdog_test_n;
    logic        pattern_select_strap_n, lamp_pattern_strap_n;
    logic        pattern_strap_present, lamp_strap_present;
    logic        host_command_data, host_command_clock;
    logic        controller_clock, controller_reset, controller_reset_n;
    logic        controller_hold_off, beeper;
    logic [10:0] grid;
    logic [15:0] anode;
    logic [15:0] mem [11];
    logic [31:0] seed = 32'ha003;
    logic [3:0]  a;
    logic [29:0] snap;
    int          n_errors = 0;
    int          checks_done = 0;
    int          t;

    display_controller #(.RESET_CYCLES(8), .DIGIT_CYCLES(DIG_N),
        .BEEP_CYCLES(BEEP_N), .WATCHDOG_CYCLES(200)) uut (
        .clk(clk), .reset(reset), .clk_en(clk_en),
        .host_bus_clock(host_bus_clock),
        .pattern_select_strap_n(pattern_select_strap_n),
        .lamp_pattern_strap_n(lamp_pattern_strap_n),
        .pattern_strap_present(pattern_strap_present),
        .lamp_strap_present(lamp_strap_present),
        .watchdog_test_n(watchdog_test_n),
        .host_command_data(host_command_data),
        .host_command_clock(host_command_clock),
        .controller_clock(controller_clock),
        .controller_reset(controller_reset),
        .controller_reset_n(controller_reset_n),
        .controller_hold_off(controller_hold_off),
        .grid(grid), .anode(anode), .beeper(beeper));

    host_link host (.clk(clk), .hold_off(controller_hold_off),
        .cmd_data(host_command_data), .cmd_clock(host_command_clock));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) host_bus_clock <= ~host_bus_clock;

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic fill_model(input logic tst, input logic lmp);
        for (int i = 0; i < 11; i++) begin
            case ({tst, lmp})
                2'b11: mem[i] = 16'h0000;
                2'b10: mem[i] = 16'hffff;
                2'b01: mem[i] = i[0] ? 16'h5555 : 16'haaaa;
                default: mem[i] = i[0] ? 16'h0f0f : 16'hf0f0;
            endcase
        end
    endtask

    // Two full scans, each slot judged at the grid change
    task automatic check_scan();
        logic [10:0] g;
        int          idx, prv, n;
        prv = -1;
        repeat (22) begin
            g = grid;
            n = 0;
            while (grid === g && n < 20) begin
                step();
                n++;
            end
            idx = -1;
            for (int i = 0; i < 11; i++) if (grid === (11'h1 << i)) idx = i;
            check(idx >= 0, 1, "one grid");
            if (idx >= 0) check(anode, mem[idx], "anode");
            if (prv >= 0) check(idx, (prv + 1) % 11, "order");
            if (prv >= 0) check(n, DIG_N, "slot length");
            prv = idx;
        end
    endtask

    task automatic do_reset(input logic ps, lp, pp, lpr);
        int   beeps;
        logic tst, lmp;
        tst = pp ? ps : 1'b1;
        lmp = lpr ? lp : 1'b0;
        beeps = 0;
        t = 0;
        @(posedge clk);
        pattern_select_strap_n <= ps;
        lamp_pattern_strap_n   <= lp;
        pattern_strap_present  <= pp;
        lamp_strap_present     <= lpr;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        check({grid, anode}, 0, "idle drive");
        check({controller_reset, controller_reset_n, controller_hold_off},
              3'b101, "reset levels");
        while (controller_hold_off !== 1'b0 && t < 200) begin
            step();
            t++;
            if (beeper === 1'b1) beeps++;
        end
        check(controller_hold_off, 0, "hold-off release");
        check(controller_reset, 0, "reset first");
        check(controller_reset_n, 1, "reset_n high");
        repeat (40) begin
            step();
            if (beeper === 1'b1) beeps++;
        end
        check(beeps, tst ? 0 : BEEP_N, "beep");
        fill_model(tst, lmp);
        check_scan();
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        $display("MISMATCH %0t run timed out", $time);
        summarize();
    end

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        host_bus_clock = 1'b0;
        watchdog_test_n = 1'b0;
        pattern_select_strap_n = 1'b1;
        lamp_pattern_strap_n = 1'b0;
        pattern_strap_present = 1'b0;
        lamp_strap_present = 1'b0;
        do_reset(1, 1, 1, 1);
        do_reset(1, 0, 1, 1);
        do_reset(0, 1, 1, 1);
        do_reset(0, 0, 1, 1);
        do_reset(0, 1, 0, 0);
        // Half-rate square wave from the bus clock
        t = 0;
        while (controller_clock === 1'b0 && t < 10) begin
            step();
            t++;
        end
        repeat (4) begin
            a[0] = controller_clock;
            t = 0;
            while (controller_clock === a[0] && t < 10) begin
                step();
                t++;
            end
            check(t, 2, "clock run");
        end
        // Nothing moves while the clock enable is low
        @(posedge clk);
        clk_en <= 1'b0;
        step();
        snap = {controller_clock, controller_reset, controller_hold_off,
                grid, anode};
        repeat (12) step();
        check(snap, {controller_clock, controller_reset, controller_hold_off,
                     grid, anode}, "frozen");
        @(posedge clk);
        clk_en <= 1'b1;
        // Random words, one to an address past the last digit
        for (int n = 0; n < 5; n++) begin
            seed = xs(seed);
            a = (n == 2) ? 4'hb : 4'(seed[31:16] % 11);
            host.send({a, seed[15:0]}, n[0] ? 3 : 2);
            if (a < 4'hb) mem[a] = seed[15:0];
        end
        repeat (3) step();
        check_scan();
        t = 0;
        repeat (300) begin
            step();
            if (controller_hold_off !== 1'b0) t++;
        end
        check(t, 0, "watchdog off");
        @(posedge clk);
        watchdog_test_n <= 1'b1;
        host.send({4'h3, 16'h1234}, 2);
        t = 0;
        while (controller_hold_off !== 1'b1 && t < 400) begin
            step();
            t++;
        end
        check(t >= 150 && t <= 260, 1, "watchdog fire");
        t = 0;
        while (controller_hold_off !== 1'b0 && t < 100) begin
            step();
            t++;
        end
        @(posedge clk);
        watchdog_test_n <= 1'b0;
        fill_model(1'b1, 1'b0);
        check_scan();
        summarize();
    end
endmodule // fluorescent_display_controller_tb_top
